// ### common/tapx_pkg.sv
// constants, state codes and next-state function for the test access port
package tapx_pkg;

  localparam int          TAPX_IR_W         = 4;
  localparam int          TAPX_DR_W         = 32;
  localparam logic [3:0]  TAPX_IR_CAPTURE   = 4'h1;
  localparam logic [3:0]  TAPX_OP_IDCODE    = 4'h1;
  localparam logic [3:0]  TAPX_OP_BYPASS    = 4'hF;
  // identification word: arbitrary neutral value, bit 0 set as boundary-scan expects
  localparam logic [31:0] TAPX_IDCODE_VALUE = 32'h0000_1001;
  localparam logic [15:0] TAPX_BOOT_ROUTINE = 16'hFFFE;
  localparam logic [15:0] TAPX_BOOT_DIRECT  = 16'h0000;

  // gray steps along reset, idle, select, capture, shift, exit1, pause, exit2, update
  typedef enum logic [3:0] {
    TAPX_RESET    = 4'h0,
    TAPX_IDLE     = 4'h1,
    TAPX_SEL_DR   = 4'h3,
    TAPX_CAP_DR   = 4'h2,
    TAPX_SHIFT_DR = 4'h6,
    TAPX_EXIT1_DR = 4'h7,
    TAPX_PAUSE_DR = 4'h5,
    TAPX_EXIT2_DR = 4'h4,
    TAPX_UPD_DR   = 4'hC,
    TAPX_SEL_IR   = 4'hD,
    TAPX_CAP_IR   = 4'hF,
    TAPX_SHIFT_IR = 4'hE,
    TAPX_EXIT1_IR = 4'hA,
    TAPX_PAUSE_IR = 4'hB,
    TAPX_EXIT2_IR = 4'h9,
    TAPX_UPD_IR   = 4'h8
  } tapx_state_e;

  function automatic tapx_state_e tapx_next(input tapx_state_e st, input logic tms);
    tapx_state_e nx;
    nx = st;
    unique case (st)
      TAPX_RESET:    nx = tms ? TAPX_RESET    : TAPX_IDLE;
      TAPX_IDLE:     nx = tms ? TAPX_SEL_DR   : TAPX_IDLE;
      TAPX_SEL_DR:   nx = tms ? TAPX_SEL_IR   : TAPX_CAP_DR;
      TAPX_CAP_DR:   nx = tms ? TAPX_EXIT1_DR : TAPX_SHIFT_DR;
      TAPX_SHIFT_DR: nx = tms ? TAPX_EXIT1_DR : TAPX_SHIFT_DR;
      TAPX_EXIT1_DR: nx = tms ? TAPX_UPD_DR   : TAPX_PAUSE_DR;
      TAPX_PAUSE_DR: nx = tms ? TAPX_EXIT2_DR : TAPX_PAUSE_DR;
      TAPX_EXIT2_DR: nx = tms ? TAPX_UPD_DR   : TAPX_SHIFT_DR;
      TAPX_UPD_DR:   nx = tms ? TAPX_SEL_DR   : TAPX_IDLE;
      TAPX_SEL_IR:   nx = tms ? TAPX_RESET    : TAPX_CAP_IR;
      TAPX_CAP_IR:   nx = tms ? TAPX_EXIT1_IR : TAPX_SHIFT_IR;
      TAPX_SHIFT_IR: nx = tms ? TAPX_EXIT1_IR : TAPX_SHIFT_IR;
      TAPX_EXIT1_IR: nx = tms ? TAPX_UPD_IR   : TAPX_PAUSE_IR;
      TAPX_PAUSE_IR: nx = tms ? TAPX_EXIT2_IR : TAPX_PAUSE_IR;
      TAPX_EXIT2_IR: nx = tms ? TAPX_UPD_IR   : TAPX_SHIFT_IR;
      TAPX_UPD_IR:   nx = tms ? TAPX_SEL_DR   : TAPX_IDLE;
    endcase
    return nx;
  endfunction

endpackage

// ### core/tapx_top.sv
// test access port, full-scan gate and dsp halt / boot strap pin
// How it works
// - all tap logic runs on the test port clock only
// - state moves on rising test clock edges, steered by tms
// - in shift states bits enter serially from tdi, one per clock
// - in shift states the selected register leaves serially on tdo
// - test reset forces the state machine to reset without a clock
// - full scan active only when scan mode pin and tdi both high
// - scan mode pin high turns tdi into scan gate, not test data
// - halt pin driven high while the dsp is told to stop
// - halt pin read as boot strap in reset: low boot routine, high address zero
`timescale 1ns/100ps
module tapx_top
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_test_port_clock,
  input  wire logic        i_test_reset_n,
  input  wire logic        i_tms,
  input  wire logic        i_tdi,
  output logic             o_tdo,
  output logic             o_tdo_oe_n,
  input  wire logic        i_scan_test_mode_pin,
  output logic             o_full_scan_gate,
  input  wire logic        i_dsp_stop_req,
  input  wire logic        i_halt_pin,
  output logic             o_halt_pin,
  output logic             o_halt_pin_oe_n,
  output logic             o_boot_direct,
  output logic [15:0]      o_boot_addr
);
  import tapx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // test clock domain

  tapx_state_e           state_r;
  tapx_state_e           state_nxt;
  logic [TAPX_IR_W-1:0]  ir_shift_r;
  logic [TAPX_IR_W-1:0]  ir_r;
  logic [TAPX_DR_W-1:0]  dr_shift_r;
  logic                  bypass_r;
  logic                  tscan_s1_r;
  logic                  tscan_s2_r;
  logic                  shift_in;
  logic                  sel_id;
  logic                  tdo_src;
  logic                  shifting;

  // scan mode pin is a static strap, still synchronised before use
  always_ff @(posedge i_test_port_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      tscan_s1_r <= 1'h0;
      tscan_s2_r <= 1'h0;
    end else begin
      tscan_s1_r <= i_scan_test_mode_pin;
      tscan_s2_r <= tscan_s1_r;
    end
  end

  always_comb begin
    state_nxt = tapx_next(state_r, i_tms);
    shift_in  = tscan_s2_r ? 1'h0 : i_tdi;
    sel_id    = (ir_r == TAPX_OP_IDCODE);
    shifting  = (state_r == TAPX_SHIFT_IR) || (state_r == TAPX_SHIFT_DR);
    if (state_r == TAPX_SHIFT_IR) begin
      tdo_src = ir_shift_r[0];
    end else if (sel_id) begin
      tdo_src = dr_shift_r[0];
    end else begin
      tdo_src = bypass_r;
    end
  end

  // trst acts at once; tms only matters on a rising clock
  always_ff @(posedge i_test_port_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      state_r <= TAPX_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // instruction path
  always_ff @(posedge i_test_port_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      ir_shift_r <= TAPX_IR_CAPTURE;
      ir_r       <= TAPX_OP_IDCODE;
    end else begin
      unique case (state_r)
        TAPX_RESET: begin
          ir_r <= TAPX_OP_IDCODE;
        end
        TAPX_CAP_IR: begin
          ir_shift_r <= TAPX_IR_CAPTURE;
        end
        TAPX_SHIFT_IR: begin
          ir_shift_r <= {shift_in, ir_shift_r[TAPX_IR_W-1:1]};
        end
        TAPX_UPD_IR: begin
          ir_r <= ir_shift_r;
        end
        default: begin
          ir_r <= ir_r;
        end
      endcase
    end
  end

  // data path: identification word or one-bit bypass; others fall to bypass
  always_ff @(posedge i_test_port_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      dr_shift_r <= TAPX_IDCODE_VALUE;
      bypass_r   <= 1'h0;
    end else if (state_r == TAPX_CAP_DR) begin
      dr_shift_r <= TAPX_IDCODE_VALUE;
      bypass_r   <= 1'h0;
    end else if (state_r == TAPX_SHIFT_DR) begin
      if (sel_id) begin
        dr_shift_r <= {shift_in, dr_shift_r[TAPX_DR_W-1:1]};
      end else begin
        bypass_r <= shift_in;
      end
    end
  end

  // tdo changes on the falling edge so the tester samples a settled bit
  always_ff @(negedge i_test_port_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      o_tdo      <= 1'h0;
      o_tdo_oe_n <= 1'h1;
    end else begin
      o_tdo      <= shifting ? tdo_src : 1'h0;
      o_tdo_oe_n <= ~shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system clock domain

  logic  scan_s1_r;
  logic  scan_s2_r;
  logic  tdi_s1_r;
  logic  tdi_s2_r;
  logic  halt_s1_r;
  logic  halt_s2_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scan_s1_r <= 1'h0;
      scan_s2_r <= 1'h0;
      tdi_s1_r  <= 1'h0;
      tdi_s2_r  <= 1'h0;
    end else begin
      scan_s1_r <= i_scan_test_mode_pin;
      scan_s2_r <= scan_s1_r;
      tdi_s1_r  <= i_tdi;
      tdi_s2_r  <= tdi_s1_r;
    end
  end

  // strap pin must stay sampled through reset, so no reset on these
  always_ff @(posedge i_clk) begin
    halt_s1_r <= i_halt_pin;
    halt_s2_r <= halt_s1_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_full_scan_gate <= 1'h0;
    end else begin
      o_full_scan_gate <= scan_s2_r & tdi_s2_r;
    end
  end

  // pin is released during reset so the board strap can be read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_halt_pin      <= 1'h0;
      o_halt_pin_oe_n <= 1'h1;
    end else begin
      o_halt_pin      <= i_dsp_stop_req;
      o_halt_pin_oe_n <= 1'b0;
    end
  end

  // last value seen in reset is kept after release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_boot_direct <= halt_s2_r;
      o_boot_addr   <= halt_s2_r ? TAPX_BOOT_DIRECT : TAPX_BOOT_ROUTINE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_trst_forces_reset: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    $rose(i_test_reset_n) |-> (state_r == TAPX_RESET))
    else $error("state not reset after test reset");

  a_five_ones_reset: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    i_tms [*5] |=> (state_r == TAPX_RESET))
    else $error("five tms ones did not reach reset");

  a_tms_low_idle: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ((state_r == TAPX_RESET) && !i_tms) |=> (state_r == TAPX_IDLE) ##1 (state_r == TAPX_IDLE || state_r == TAPX_SEL_DR))
    else $error("tms low did not leave reset to idle");

  a_shift_in_id: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ((state_r == TAPX_SHIFT_DR) && sel_id && !tscan_s2_r) |=> (dr_shift_r[TAPX_DR_W-1] == $past(i_tdi)))
    else $error("tdi bit not shifted into data register");

  a_scan_blocks_tdi: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ((state_r == TAPX_SHIFT_DR) && !sel_id && tscan_s2_r) |=> !bypass_r)
    else $error("tdi used as data while scan mode high");

  a_tdo_ir_out: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ($past(state_r) == TAPX_SHIFT_IR && state_r == TAPX_SHIFT_IR) |-> (o_tdo == ir_shift_r[0] && !o_tdo_oe_n))
    else $error("tdo does not show instruction bit");

  a_tdo_idle_off: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    (state_r == TAPX_IDLE) ##1 (state_r == TAPX_IDLE) |-> o_tdo_oe_n)
    else $error("tdo driven outside shift");

  a_scan_gate_both: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_full_scan_gate |-> $past(scan_s2_r) && $past(tdi_s2_r))
    else $error("full scan active without both pins");

  a_halt_follows: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_dsp_stop_req |=> (o_halt_pin && !o_halt_pin_oe_n))
    else $error("halt pin not driven on dsp stop");

  a_boot_strap: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> (o_boot_direct == $past(halt_s2_r)) &&
                     (o_boot_addr == ($past(halt_s2_r) ? TAPX_BOOT_DIRECT : TAPX_BOOT_ROUTINE)))
    else $error("boot strap not captured at reset release");

  // boot choice must not drift with later pin activity
  a_boot_frozen: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> $stable(o_boot_direct) && $stable(o_boot_addr))
    else $error("boot outputs changed outside reset");

  a_halt_released: assert property (
    @(posedge i_clk)
    i_rst |=> (o_halt_pin_oe_n && !o_halt_pin))
    else $error("halt pin driven during reset");

  a_scan_gate_sets: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && $past(scan_s2_r) && $past(tdi_s2_r)) |-> o_full_scan_gate)
    else $error("full scan not active with both pins high");

  a_ir_capture_val: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    (state_r == TAPX_CAP_IR) |=> (ir_shift_r == TAPX_IR_CAPTURE))
    else $error("instruction capture value wrong");

  a_dr_capture_id: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    (state_r == TAPX_CAP_DR) |=> (dr_shift_r == TAPX_IDCODE_VALUE) && !bypass_r)
    else $error("data capture value wrong");

  a_ir_shift_in: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ((state_r == TAPX_SHIFT_IR) && !tscan_s2_r) |=> (ir_shift_r[TAPX_IR_W-1] == $past(i_tdi)))
    else $error("tdi bit not shifted into instruction register");

  // a falling edge always lies between entering shift and the next rise
  a_tdo_dr_out: assert property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    ((state_r == TAPX_SHIFT_DR) && sel_id) |-> (o_tdo == dr_shift_r[0]) && !o_tdo_oe_n)
    else $error("tdo does not show data bit");

  c_ir_update: cover property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    (state_r == TAPX_SHIFT_IR) ##[1:20] (state_r == TAPX_UPD_IR));

  c_dr_shift_long: cover property (
    @(posedge i_test_port_clock) disable iff (!i_test_reset_n)
    (state_r == TAPX_SHIFT_DR) [*8]);

  c_full_scan: cover property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_full_scan_gate));

  c_halt: cover property (
    @(posedge i_clk) disable iff (i_rst)
    $rose(o_halt_pin));

  c_trst_release: cover property (
    @(posedge i_test_port_clock)
    $rose(i_test_reset_n));

endmodule

// ### testbench/tapx_host.sv
// tester model: drives test clock, mode select and data in, reads data out
`timescale 1ns/100ps
module tapx_host (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n,
  input  wire logic i_tdo
);
  initial begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h1;
    o_trst_n = 1'h0;
  end
  task automatic set_trst(input logic v);
    o_trst_n = v;
  endtask
  task automatic set_tdi(input logic v);
    o_tdi = v;
  endtask
  // clock stands low between frames; tdo taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #32;
    tdo = i_tdo;
    o_tck = 1'h1;
    #32;
    o_tck = 1'h0;
  endtask
  // lsb first, tms high on the last bit to leave the shift state
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], b);
      dout[k] = b;
    end
    o_tdi = 1'h1; // pull-up once released
  endtask
endmodule

// ### testbench/tb_tapx_top.sv
// self-checking bench for the test access port block
`timescale 1ns/100ps
module tb_tapx_top;
  import tapx_pkg::*;
  logic        i_clk = 1'h0;
  logic        i_rst = 1'h1;
  logic        i_scan_test_mode_pin = 1'h0;
  logic        i_dsp_stop_req = 1'h0;
  logic        strap = 1'h1;
  logic        tck, tms, tdi, trst_n;
  logic        o_tdo, o_tdo_oe_n, o_full_scan_gate, o_halt_pin, o_halt_pin_oe_n, o_boot_direct;
  logic [15:0] o_boot_addr;
  logic [31:0] dout;
  wire logic   halt_wire = o_halt_pin_oe_n ? strap : o_halt_pin;
  int          err_total = 0;
  int          total_checks = 0;
  always #25 i_clk = ~i_clk;
  tapx_top i_tapx_top (.i_clk(i_clk), .i_rst(i_rst), .i_test_port_clock(tck), .i_test_reset_n(trst_n),
    .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n),
    .i_scan_test_mode_pin(i_scan_test_mode_pin), .o_full_scan_gate(o_full_scan_gate),
    .i_dsp_stop_req(i_dsp_stop_req), .i_halt_pin(halt_wire), .o_halt_pin(o_halt_pin),
    .o_halt_pin_oe_n(o_halt_pin_oe_n), .o_boot_direct(o_boot_direct), .o_boot_addr(o_boot_addr));
  tapx_host i_tapx_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(o_tdo));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic walk(input logic [7:0] bits, input int n);
    logic b;
    for (int k = 0; k < n; k++) i_tapx_host.step(bits[k], 1'h1, b);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // strap flipped after release to show the boot choice is frozen
  task automatic do_reset(input logic s);
    @(posedge i_clk);
    strap <= s;
    i_rst <= 1'h1;
    repeat (16) @(posedge i_clk);
    #1;
    check(o_halt_pin_oe_n, 1'h1);
    check(o_full_scan_gate, 1'h0);
    @(posedge i_clk);
    i_rst <= 1'h0;
    strap <= ~s;
    repeat (2) @(posedge i_clk);
    #1;
    check(o_halt_pin_oe_n, 1'h0);
    check(o_boot_direct, s);
    check(o_boot_addr, s ? TAPX_BOOT_DIRECT : TAPX_BOOT_ROUTINE);
    $display("test reset strap %0d done", s);
  endtask
  task automatic t_halt();
    @(posedge i_clk);
    i_dsp_stop_req <= 1'h1;
    @(posedge i_clk);
    #1;
    check(o_halt_pin, 1'h1);
    @(posedge i_clk);
    i_dsp_stop_req <= 1'h0;
    @(posedge i_clk);
    #1;
    check(o_halt_pin, 1'h0);
    $display("test halt done");
  endtask
  task automatic read_id();
    walk(8'h01, 3);
    #1;
    check(o_tdo_oe_n, 1'h0);
    i_tapx_host.shift(32, 32'hFFFF_FFFF, dout);
    check(dout, TAPX_IDCODE_VALUE);
    #1;
    check({o_tdo_oe_n, o_tdo}, 2'h2);
    walk(8'h01, 2);
  endtask
  task automatic ir_load(input logic [3:0] op);
    walk(8'h03, 4);
    i_tapx_host.shift(4, {28'h000_0000, op}, dout);
    check(dout[3:0], TAPX_IR_CAPTURE);
    walk(8'h01, 2);
  endtask
  // bypass delays by one bit; five ones then restore the id register
  task automatic t_bypass();
    ir_load(TAPX_OP_BYPASS);
    walk(8'h01, 3);
    i_tapx_host.shift(3, 32'h0000_0005, dout);
    check(dout[2:0], 3'h2);
    walk(8'h01, 2);
    walk(8'h1F, 6);
    read_id();
    $display("test bypass done");
  endtask
  // clock runs once while test reset is held; state must not move
  task automatic t_trst();
    ir_load(TAPX_OP_BYPASS);
    walk(8'h01, 3);
    #1;
    check(o_tdo_oe_n, 1'h0);
    i_tapx_host.set_trst(1'h0);
    #3;
    check({o_tdo_oe_n, o_tdo}, 2'h2);
    walk(8'h00, 1);
    #1;
    check({o_tdo_oe_n, o_tdo}, 2'h2);
    i_tapx_host.set_trst(1'h1);
    walk(8'h00, 1);
    read_id();
    $display("test trst done");
  endtask
  task automatic t_scan();
    ir_load(TAPX_OP_BYPASS);
    @(posedge i_clk);
    i_scan_test_mode_pin <= 1'h1;
    repeat (4) @(posedge i_clk);
    #1;
    check(o_full_scan_gate, 1'h1);
    i_tapx_host.set_tdi(1'h0);
    repeat (4) @(posedge i_clk);
    #1;
    check(o_full_scan_gate, 1'h0);
    i_tapx_host.set_tdi(1'h1);
    walk(8'h00, 3);
    walk(8'h01, 3);
    i_tapx_host.shift(3, 32'h0000_0007, dout);
    check(dout[2:0], 3'h0);
    walk(8'h01, 2);
    @(posedge i_clk);
    i_scan_test_mode_pin <= 1'h0;
    repeat (4) @(posedge i_clk);
    #1;
    check(o_full_scan_gate, 1'h0);
    $display("test scan done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'h1);
    do_reset(1'h0);
    i_tapx_host.set_trst(1'h1);
    t_halt();
    walk(8'h00, 1);
    read_id();
    t_bypass();
    t_trst();
    t_scan();
    conclude();
  end
  // tests take about 14 us; some fourteen times that before giving up
  initial begin
    #200_000;
    err_total++;
    conclude();
  end
endmodule
